// ==== hdl/cfg_loader_defs.svh ====
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

// ************************************
// nonvolatile word addresses and bits
// ************************************
`define NVM_PIN_WORD 8'h10
`define NVM_SIZING_WORD 8'h12
`define W_P0_VAL 0
`define W_P1_VAL 1
`define W_COLD 2
`define W_DIS1000 3
`define W_GIG_DIS 4
`define W_WDG 5
`define W_P2_VAL 6
`define W_P3_VAL 7
`define W_P0_DIR 8
`define W_P1_DIR 9

// ************************************
// control register fields
// ************************************
`define C_P0_DATA 18
`define C_P1_DATA 19
`define C_COLD 20
`define C_WDE 21
`define C_P0_DIR 22
`define C_P1_DIR 23
`define CTRL_MASK 32'h00fc_0000
`define CTRL_RST 32'h0010_0000
`define X_P2_DATA 6
`define X_P3_DATA 7
`define X_P2_DIR 10
`define X_P3_DIR 11
`define EXT_MASK 32'h0000_0cc0
`define EXT_RST 32'h0000_0000

// ************************************
// register map and sub-fields
// ************************************
`define OFF_CTRL 8'h00
`define OFF_EXT 8'h04
`define OFF_NVRD 8'h08
`define OFF_NVWR 8'h0c
`define OFF_STAT 8'h10
`define F_START 0
`define F_REFUSED 1
`define F_DONE 4
`define F_ADDR 8
`define F_DATA 16
`define S_LOADED 0
`define S_GIG_DIS 1
`define S_DIS1000 2
`define S_WORD 16
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ==== hdl/cfg_loader_pkg.sv ====
`default_nettype none
package cfg_loader_pkg;
  typedef logic [7:0] nvm_addr_t;
  typedef logic [15:0] nvm_word_t;
  typedef enum logic [1:0] {LD_FETCH, LD_WAIT, LD_RUN} load_state_t;
  typedef enum logic [1:0] {SW_IDLE, SW_RD, SW_WR} sw_op_t;
endpackage
`default_nettype wire

// ==== hdl/nvm_word_port.sv ====
`default_nettype none
module nvm_word_port
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire cfg_loader_pkg::nvm_addr_t cmd_addr,
  input wire cfg_loader_pkg::nvm_word_t cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output cfg_loader_pkg::nvm_word_t rdata,
  output logic nvm_req,
  output logic nvm_we,
  output cfg_loader_pkg::nvm_addr_t nvm_addr,
  output cfg_loader_pkg::nvm_word_t nvm_wdata,
  input wire logic nvm_ack,
  input wire cfg_loader_pkg::nvm_word_t nvm_rdata
);
  import cfg_loader_pkg::*;

  // request held until the memory acknowledges it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_req <= 1'b0;
      nvm_we <= 1'b0;
      nvm_addr <= '0;
      nvm_wdata <= '0;
    end else if (cmd_valid && cmd_ready) begin
      nvm_req <= 1'b1;
      nvm_we <= cmd_write;
      nvm_addr <= cmd_addr;
      nvm_wdata <= cmd_wdata;
    end else if (nvm_req && nvm_ack) begin
      nvm_req <= 1'b0;
    end
  end

  // ready low from the command edge until the ack edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ready <= 1'b1;
    end else if (cmd_valid && cmd_ready) begin
      cmd_ready <= 1'b0;
    end else if (nvm_req && nvm_ack) begin
      cmd_ready <= 1'b1;
    end
  end

  // one-cycle completion pulse; the word is captured only on read acks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      rdata <= '0;
    end else begin
      done <= nvm_req && nvm_ack;
      if (nvm_req && nvm_ack && !nvm_we) begin
        rdata <= nvm_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/pin_init_config_loader.sv ====
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
`include "cfg_loader_defs.svh"
module pin_init_config_loader #(
  parameter int AXI_AW = 8,
  parameter int PINS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fw_auth_valid,
  input wire logic watchdog_timeout,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic nvm_req,
  output logic nvm_we,
  output cfg_loader_pkg::nvm_addr_t nvm_addr,
  output cfg_loader_pkg::nvm_word_t nvm_wdata,
  input wire logic nvm_ack,
  input wire cfg_loader_pkg::nvm_word_t nvm_rdata
);
  import cfg_loader_pkg::*;

  // ************************************
  // elaboration checks
  // ************************************
  // the map needs five word slots; pin mapping is fixed at four
  if (AXI_AW < 5) begin : g_bad_aw
    $error("AXI_AW must be at least 5");
  end
  if (PINS != 4) begin : g_bad_pins
    $error("PINS must be 4");
  end

  // ************************************
  // declarations
  // ************************************
  load_state_t ld_q;
  sw_op_t sw_q;
  logic loaded_q;
  logic [31:0] ctrl_q;
  logic [31:0] ext_q;
  nvm_word_t word_q;
  nvm_word_t sw_rdata_q;
  logic sw_done_q;
  logic refused_q;
  logic aw_full_q;
  logic w_full_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] wmask;
  logic [31:0] wmerge_ctrl;
  logic [31:0] wmerge_ext;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic aw_full_d;
  logic w_full_d;
  logic bvalid_d;
  logic rvalid_d;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic wr_ctrl;
  logic wr_ext;
  logic wr_nvrd;
  logic wr_nvwr;
  logic wr_known;
  logic rd_known;
  logic [31:0] rd_word;
  logic cmd_valid;
  logic cmd_write;
  nvm_addr_t cmd_addr;
  nvm_word_t cmd_wdata;
  logic cmd_ready;
  logic port_done;
  nvm_word_t port_rdata;
  logic sw_rd_go;
  logic sw_wr_go;
  logic sw_wr_bad;
  logic [PINS-1:0] pin_dir;
  logic [PINS-1:0] pin_data;

  // ************************************
  // nonvolatile memory port
  // ************************************
  nvm_word_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_valid(cmd_valid),
    .cmd_write(cmd_write),
    .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready),
    .done(port_done),
    .rdata(port_rdata),
    .nvm_req(nvm_req),
    .nvm_we(nvm_we),
    .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata),
    .nvm_ack(nvm_ack),
    .nvm_rdata(nvm_rdata)
  );

  // ************************************
  // axi4-lite handshakes
  // ************************************
  // write fires only once address and data are both held
  always_comb begin
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    ar_hs = s_axi_arvalid && s_axi_arready;
    wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    aw_full_d = aw_hs ? 1'b1 : (wr_fire ? 1'b0 : aw_full_q);
    w_full_d = w_hs ? 1'b1 : (wr_fire ? 1'b0 : w_full_q);
    bvalid_d = wr_fire ? 1'b1 : ((s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid);
    rvalid_d = ar_hs ? 1'b1 : ((s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid);
  end

  // address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // ready flags registered; held low while a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full_d && !bvalid_d;
      s_axi_wready <= !w_full_d && !bvalid_d;
      s_axi_arready <= !rvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_rvalid <= rvalid_d;
    end
  end

  // ************************************
  // address decode
  // ************************************
  always_comb begin
    wr_off = 8'({aw_addr_q[AXI_AW-1:2], 2'b00});
    rd_off = 8'({s_axi_araddr[AXI_AW-1:2], 2'b00});
    wr_ctrl = wr_fire && (wr_off == `OFF_CTRL);
    wr_ext = wr_fire && (wr_off == `OFF_EXT);
    wr_nvrd = wr_fire && (wr_off == `OFF_NVRD);
    wr_nvwr = wr_fire && (wr_off == `OFF_NVWR);
    wr_known = wr_off inside {`OFF_CTRL, `OFF_EXT, `OFF_NVRD, `OFF_NVWR, `OFF_STAT};
    rd_known = rd_off inside {`OFF_CTRL, `OFF_EXT, `OFF_NVRD, `OFF_NVWR, `OFF_STAT};
    wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wmerge_ctrl = ((ctrl_q & ~wmask) | (w_data_q & wmask)) & `CTRL_MASK;
    wmerge_ext = ((ext_q & ~wmask) | (w_data_q & wmask)) & `EXT_MASK;
  end

  // write response; unmapped offsets answer decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_DECERR;
    end
  end

  // read mux; soft flags shown but never acted on
  always_comb begin
    rd_word = '0;
    unique case (rd_off)
      `OFF_CTRL: rd_word = ctrl_q;
      `OFF_EXT: rd_word = ext_q;
      `OFF_NVRD: begin
        rd_word[`F_DONE] = sw_done_q;
        rd_word[`F_DATA +: 16] = sw_rdata_q;
      end
      `OFF_NVWR: rd_word[`F_REFUSED] = refused_q;
      `OFF_STAT: begin
        rd_word[`S_LOADED] = loaded_q;
        rd_word[`S_GIG_DIS] = word_q[`W_GIG_DIS];
        rd_word[`S_DIS1000] = word_q[`W_DIS1000];
        rd_word[`S_WORD +: 16] = word_q; // whole word; policy is software's
      end
      default: rd_word = '0;
    endcase
  end

  // read data registered with the handshake, one cycle latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_DECERR;
    end
  end

  // ************************************
  // power-up load sequence
  // ************************************
  // one fetch of the pin word, then the port serves software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ld_q <= LD_FETCH;
      loaded_q <= 1'b0;
      word_q <= '0;
    end else begin
      unique case (ld_q)
        LD_FETCH: begin
          if (cmd_ready) begin
            ld_q <= LD_WAIT;
          end
        end
        LD_WAIT: begin
          if (port_done) begin
            ld_q <= LD_RUN;
            loaded_q <= 1'b1;
            word_q <= port_rdata;
          end
        end
        LD_RUN: ld_q <= LD_RUN;
      endcase
    end
  end

  // ************************************
  // software access to the memory
  // ************************************
  // sizing word writes only pass with firmware authentication
  always_comb begin
    sw_rd_go = wr_nvrd && w_data_q[`F_START] && loaded_q && sw_q == SW_IDLE && cmd_ready;
    sw_wr_go = wr_nvwr && w_data_q[`F_START] && loaded_q && sw_q == SW_IDLE && cmd_ready;
    sw_wr_bad = sw_wr_go && (w_data_q[`F_ADDR +: 8] == `NVM_SIZING_WORD) && !fw_auth_valid;
  end

  // command steering: load fetch first, software afterwards
  always_comb begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = `NVM_PIN_WORD;
    cmd_wdata = '0;
    if (ld_q == LD_FETCH) begin
      cmd_valid = 1'b1;
    end else if (sw_rd_go) begin
      cmd_valid = 1'b1;
      cmd_addr = w_data_q[`F_ADDR +: 8];
    end else if (sw_wr_go && !sw_wr_bad) begin
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_addr = w_data_q[`F_ADDR +: 8];
      cmd_wdata = w_data_q[`F_DATA +: 16];
    end
  end

  // software operation tracking and read result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= SW_IDLE;
      sw_done_q <= 1'b0;
      sw_rdata_q <= '0;
    end else begin
      unique case (sw_q)
        SW_IDLE: begin
          if (sw_rd_go) begin
            sw_q <= SW_RD;
            sw_done_q <= 1'b0;
          end else if (sw_wr_go && !sw_wr_bad) begin
            sw_q <= SW_WR;
          end
        end
        SW_RD: begin
          if (port_done) begin
            sw_q <= SW_IDLE;
            sw_done_q <= 1'b1;
            sw_rdata_q <= port_rdata;
          end
        end
        SW_WR: begin
          if (port_done) begin
            sw_q <= SW_IDLE;
          end
        end
        default: sw_q <= SW_IDLE;
      endcase
    end
  end

  // refused flag: write one clears, a new refusal wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_q <= 1'b0;
    end else if (sw_wr_bad) begin
      refused_q <= 1'b1;
    end else if (wr_nvwr && w_data_q[`F_REFUSED] && w_strb_q[0]) begin
      refused_q <= 1'b0;
    end
  end

  // ************************************
  // control registers
  // ************************************
  // loaded presets land once; software writes before the load are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRL_RST;
    end else if (ld_q == LD_WAIT && port_done) begin
      ctrl_q <= `CTRL_RST;
      ctrl_q[`C_P0_DATA] <= port_rdata[`W_P0_VAL];
      ctrl_q[`C_P1_DATA] <= port_rdata[`W_P1_VAL];
      ctrl_q[`C_COLD] <= port_rdata[`W_COLD];
      ctrl_q[`C_WDE] <= port_rdata[`W_WDG];
      ctrl_q[`C_P0_DIR] <= port_rdata[`W_P0_DIR];
      ctrl_q[`C_P1_DIR] <= port_rdata[`W_P1_DIR];
    end else if (wr_ctrl && loaded_q) begin
      ctrl_q <= wmerge_ctrl;
    end
  end

  // extended control: pin 2 and 3 data from the word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= `EXT_RST;
    end else if (ld_q == LD_WAIT && port_done) begin
      ext_q <= `EXT_RST;
      ext_q[`X_P2_DATA] <= port_rdata[`W_P2_VAL];
      ext_q[`X_P3_DATA] <= port_rdata[`W_P3_VAL];
    end else if (wr_ext && loaded_q) begin
      ext_q <= wmerge_ext;
    end
  end

  // ************************************
  // software defined pins
  // ************************************
  // gather per-pin direction and level from the two registers
  always_comb begin
    pin_dir = {ext_q[`X_P3_DIR], ext_q[`X_P2_DIR], ctrl_q[`C_P1_DIR], ctrl_q[`C_P0_DIR]};
    pin_data = {ext_q[`X_P3_DATA], ext_q[`X_P2_DATA], ctrl_q[`C_P1_DATA], ctrl_q[`C_P0_DATA]};
  end

  // drivers stay off until loaded, so no default level ever escapes
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out[i] <= 1'b0;
        pin_oe[i] <= 1'b0;
      end else if (!loaded_q) begin
        pin_out[i] <= 1'b0;
        pin_oe[i] <= 1'b0;
      end else if (i == 0 && ctrl_q[`C_WDE]) begin
        pin_out[i] <= watchdog_timeout;
        pin_oe[i] <= 1'b1;
      end else begin
        pin_out[i] <= pin_data[i];
        pin_oe[i] <= pin_dir[i];
      end
    end
  end

  // pin inputs are sampled by other logic; this block only drives
  logic unused_pins;
  assign unused_pins = ^pin_in;
endmodule
`default_nettype wire

// ==== dv/pin_init_config_loader_properties.sv ====
`default_nettype none
`include "cfg_loader_defs.svh"
module loader_props #(
  parameter int AXI_AW = 8,
  parameter int PINS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic watchdog_timeout,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire cfg_loader_pkg::nvm_addr_t nvm_addr,
  input wire logic nvm_ack,
  input wire cfg_loader_pkg::nvm_word_t nvm_rdata
);
  // ****************************
  // load tracking and properties
  // ****************************
  logic seen_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // first ack after reset is the pin word load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_q <= 1'b0;
    end else if (nvm_ack) begin
      seen_q <= 1'b1;
    end
  end

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_nvm_hold: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr) && $stable(nvm_we))
    else $error("memory request changed before ack");
  a_first_fetch: assert property ($rose(aresetn) |-> ##[1:3]
    (nvm_req && nvm_addr == `NVM_PIN_WORD && !nvm_we))
    else $error("pin word not fetched after reset");
  a_pins_unloaded: assert property (!seen_q |-> pin_oe == '0 && pin_out == '0)
    else $error("pins driven before word loaded");
  a_pin_preset: assert property (!seen_q && nvm_ack |-> ##4
    pin_out[3:1] == {$past(nvm_rdata[7], 4), $past(nvm_rdata[6], 4), $past(nvm_rdata[1], 4)}
    && pin_oe[3:1] == {2'b00, $past(nvm_rdata[9], 4)})
    else $error("pins 1 to 3 not preset from word");
  a_pin0_preset: assert property (!seen_q && nvm_ack && !nvm_rdata[5] |-> ##4
    pin_out[0] == $past(nvm_rdata[0], 4) && pin_oe[0] == $past(nvm_rdata[8], 4))
    else $error("pin 0 not preset from word");
  a_wdg_pin0: assert property (!seen_q && nvm_ack && nvm_rdata[5] |-> ##4
    pin_oe[0] && pin_out[0] == $past(watchdog_timeout))
    else $error("pin 0 does not carry watchdog");

  c_load: cover property (!seen_q && nvm_ack);
  c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'b11);
  c_nvm_write: cover property (nvm_req && nvm_we);
endmodule

bind pin_init_config_loader loader_props #(.AXI_AW(AXI_AW), .PINS(PINS)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .watchdog_timeout(watchdog_timeout),
  .pin_out(pin_out), .pin_oe(pin_oe), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
  .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata));
`default_nettype wire

// ==== dv/nvm_model.sv ====
`default_nettype none
module nvm_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] lat,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire cfg_loader_pkg::nvm_addr_t nvm_addr,
  input wire cfg_loader_pkg::nvm_word_t nvm_wdata,
  output logic nvm_ack,
  output cfg_loader_pkg::nvm_word_t nvm_rdata
);
  import cfg_loader_pkg::*;
  // ****************************
  // word memory with slow answer
  // ****************************
  nvm_word_t mem [256];
  int cnt;
  int wr_cnt = 0;

  // data toggles outside the ack cycle so a late sample shows up
  always @(posedge aclk) begin
    nvm_ack <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (!aresetn) begin
      cnt <= 0;
      nvm_rdata <= 16'h5a5a;
    end else if (nvm_req && !nvm_ack) begin
      if (cnt >= lat) begin
        cnt <= 0;
        nvm_ack <= 1'b1;
        if (nvm_we) begin
          mem[nvm_addr] <= nvm_wdata;
          wr_cnt <= wr_cnt + 1;
        end else begin
          nvm_rdata <= mem[nvm_addr];
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`default_nettype none
`include "cfg_loader_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cfg_loader_pkg::*;
  // ****************************
  // stimulus and checking
  // ****************************
  localparam int LIM = 200;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, auth = 0, wdt = 0;
  logic [7:0] awa = 0, ara = 0, lat = 8'h14;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0, pout, poe;
  logic awr, wr_rdy, bv, arr, rv, req, we, ack;
  logic [1:0] br, rr;
  nvm_addr_t na;
  nvm_word_t nwd, nrd;
  int bad_count = 0;
  int num_checks = 0;

  initial forever #2.5 aclk = ~aclk;

  pin_init_config_loader uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .fw_auth_valid(auth), .watchdog_timeout(wdt), .pin_in(4'ha), .pin_out(pout), .pin_oe(poe),
    .nvm_req(req), .nvm_we(we), .nvm_addr(na), .nvm_wdata(nwd), .nvm_ack(ack), .nvm_rdata(nrd));
  nvm_model u_mem (.aclk(aclk), .aresetn(aresetn), .lat(lat), .nvm_req(req), .nvm_we(we), .nvm_addr(na),
    .nvm_wdata(nwd), .nvm_ack(ack), .nvm_rdata(nrd));

  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  // a used-up wait ends the run rather than hang
  task tmo(input int n);
    if (n >= LIM) begin
      bad_count++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      report_and_stop;
    end
  endtask

  // bready raised late on purpose so the response has to stand
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ad;
    logic dd;
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    ws <= 4'hf;
    wv <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    for (n = 0; n < LIM && !(ad && dd); n++) begin
      @(posedge aclk);
      if (awv && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr_rdy) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    tmo(n);
    for (n = 0; n < LIM && !bv; n++) begin
      @(posedge aclk);
    end
    tmo(n);
    bre <= 1'b1;
    @(posedge aclk);
    r = br;
    bre <= 1'b0;
  endtask

  task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < LIM && !(arv && arr); n++) begin
      @(posedge aclk);
    end
    tmo(n);
    arv <= 1'b0;
    for (n = 0; n < LIM && !rv; n++) begin
      @(posedge aclk);
    end
    tmo(n);
    rre <= 1'b1;
    @(posedge aclk);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask

  initial begin
    int i;
    int n;
    logic [31:0] v;
    logic [1:0] r;
    nvm_word_t w;
    u_mem.mem[8'h12] = 16'h4321;
    // two complementary words, each loaded after its own reset
    for (i = 0; i < 2; i++) begin
      w = (i == 0) ? 16'h0155 : 16'h02aa;
      u_mem.mem[`NVM_PIN_WORD] = w;
      aresetn <= 1'b0;
      wdt <= i[0];
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`OFF_CTRL, 32'h0, r);
      rdr(`OFF_CTRL, v, r);
      chk(v, `CTRL_RST, "ctrl before load");
      rdr(`OFF_EXT, v, r);
      chk(v, `EXT_RST, "ext before load");
      chk({poe, pout}, 8'h00, "pins before load");
      for (n = 0; n < LIM; n++) begin
        rdr(`OFF_STAT, v, r);
        if (v[`S_LOADED]) break;
      end
      tmo(n);
      chk(v, {w, 13'h0, w[3], w[4], 1'b1}, "status");
      rdr(`OFF_CTRL, v, r);
      chk(v, {8'h0, w[9], w[8], w[5], w[2], w[1], w[0], 18'h0}, "ctrl");
      rdr(`OFF_EXT, v, r);
      chk(v, {24'h0, w[7], w[6], 6'h0}, "ext");
      chk({pout, poe}, {w[7], w[6], w[1], w[5] ? i[0] : w[0], 2'b00, w[9], w[5] | w[8]}, "pins");
      $display("load test %0d done", i);
    end
    // decode of an unmapped offset
    wr(8'h14, 32'hffffffff, r);
    chk({30'h0, r}, {30'h0, `RESP_DECERR}, "unmapped write");
    rdr(8'h14, v, r);
    chk({v[29:0], r}, {30'h0, `RESP_DECERR}, "unmapped read");
    $display("decode test done");
    // word 12h: readable, write needs authenticated firmware
    lat <= 8'h02;
    wr(`OFF_NVRD, 32'h0000_1201, r);
    for (n = 0; n < LIM; n++) begin
      rdr(`OFF_NVRD, v, r);
      if (v[`F_DONE]) break;
    end
    tmo(n);
    chk(v[31:16], 16'h4321, "word 12h read");
    wr(`OFF_NVWR, 32'hdead_1201, r);
    rdr(`OFF_NVWR, v, r);
    chk(v[`F_REFUSED], 1'b1, "host write refused");
    wr(`OFF_NVWR, 32'h0000_0002, r);
    rdr(`OFF_NVWR, v, r);
    chk(v[`F_REFUSED], 1'b0, "refused flag cleared");
    auth <= 1'b1;
    wr(`OFF_NVWR, 32'hbeef_1201, r);
    auth <= 1'b0;
    for (n = 0; n < LIM && u_mem.wr_cnt == 0; n++) begin
      @(posedge aclk);
    end
    tmo(n);
    chk(u_mem.mem[8'h12], 16'hbeef, "firmware write");
    chk(u_mem.wr_cnt, 1, "one write issued");
    $display("nvm test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
